// ### core/tdac_defines.vh
// constants for the time-of-day alarm counter block
`ifndef TDAC_DEFINES_VH
`define TDAC_DEFINES_VH

// word address of the register block, in register words
`define TDAC_BASE_WORD      30'h0000_10c0

// register index within the block (byte address is four times the sum of base and index)
`define TDAC_IDX_CTRL       4'h0
`define TDAC_IDX_PRESCALE   4'h1
`define TDAC_IDX_SEC        4'h2
`define TDAC_IDX_SEC_ALM    4'h3
`define TDAC_IDX_MIN        4'h4
`define TDAC_IDX_MIN_ALM    4'h5
`define TDAC_IDX_HR         4'h6
`define TDAC_IDX_HR_ALM     4'h7
`define TDAC_IDX_DAY        4'h8
`define TDAC_IDX_DAY_ALM    4'h9
`define TDAC_IDX_LAST       4'h9

// control_status field positions
`define TDAC_CS_SEC_FLAG    15
`define TDAC_CS_ALM_FLAG    14
`define TDAC_CS_TEST_HI     9
`define TDAC_CS_TEST_LO     8
`define TDAC_CS_DAY_EN      7
`define TDAC_CS_HR_EN       6
`define TDAC_CS_MIN_EN      5
`define TDAC_CS_SEC_EN      4
`define TDAC_CS_SEC_IRQ_EN  3
`define TDAC_CS_ALM_IRQ_EN  2
`define TDAC_CS_CNT_EN      0

// field widths and last values before rollover
`define TDAC_SEC_W          6
`define TDAC_MIN_W          6
`define TDAC_HR_W           5
`define TDAC_DAY_W          16
`define TDAC_SEC_MAX        6'h3b
`define TDAC_MIN_MAX        6'h3b
`define TDAC_HR_MAX         5'h17
`define TDAC_DAY_MAX        16'hffff

// reset values and latch delay after the tick in bus clocks
`define TDAC_RST_16         16'h0000
`define TDAC_LATCH_DELAY    2

`endif

// ### core/tdac_sync2.v
// two flip-flop synchroniser with a chosen reset level
`timescale 1ns/100ps
module tdac_sync2 #(
   parameter RST_VAL = 1'b0
) (
   input  wire i_clk,
   input  wire i_rst_n,
   input  wire i_d,
   output reg  o_q
);

   reg meta_q;

   ////////////////////////////////////////////////////////////////////////////////
   // first stage feeds only the second stage
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= RST_VAL;
         o_q    <= RST_VAL;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end

endmodule // tdac_sync2

// ### core/tdac_time_field.v
// one modulo time counter with its read latch
`timescale 1ns/100ps
module tdac_time_field #(
   parameter          W   = 6,
   parameter [W-1:0]  MAX = 6'h3b
) (
   input  wire         i_clk,
   input  wire         i_rst_n,
   input  wire         i_inc,
   input  wire         i_load,
   input  wire [W-1:0] i_load_val,
   input  wire         i_latch,
   output reg  [W-1:0] o_cnt_q,
   output reg  [W-1:0] o_lat_q,
   output wire         o_carry
);

   // rollover when advancing from the last value (or an out of range load)
   wire wrap = (o_cnt_q >= MAX);

   assign o_carry = i_inc & wrap;

   ////////////////////////////////////////////////////////////////////////////////
   // counter: software load while stopped, advance while counting
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cnt_q <= {W{1'b0}};
      end else if (i_load) begin
         o_cnt_q <= i_load_val;
      end else if (i_inc) begin
         o_cnt_q <= wrap ? {W{1'b0}} : o_cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read latch: captures the settled counter
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_lat_q <= {W{1'b0}};
      end else if (i_latch) begin
         o_lat_q <= o_cnt_q;
      end
   end

endmodule // tdac_time_field

// ### core/tdac_top.v
// time-of-day alarm counter: prescaler, time fields, alarm and wishbone registers
`timescale 1ns/100ps
`include "tdac_defines.vh"
module tdac_top #(
   parameter PRE_W = 16
) (
   input  wire        I_SYS_CLK,
   input  wire        I_RST_N,
   input  wire        I_TOD_CLK,
   input  wire        I_WB_CYC,
   input  wire        I_WB_STB,
   input  wire        I_WB_WE,
   input  wire [31:0] I_WB_ADR,
   input  wire [3:0]  I_WB_SEL,
   input  wire [31:0] I_WB_DAT,
   output reg         O_WB_ACK,
   output reg  [31:0] O_WB_DAT,
   output reg         O_SEC_IRQ,
   output reg         O_ALARM_IRQ
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   wire                   rst_n;          // synchronised reset release
   wire                   tod_clk_s;      // synchronised time-base input
   reg                    tod_clk_q;      // previous sample for edge detect
   wire                   tod_rise;

   reg  [15:0]            ctrl_q;         // stored control bits, flags included
   reg  [PRE_W-1:0]       pre_load_q;
   reg  [PRE_W-1:0]       pre_cnt_q;
   reg                    tick_q;         // one-cycle 1 Hz tick
   reg  [`TDAC_LATCH_DELAY-1:0] tick_dly_q;
   reg                    alarm_chk_q;    // latches just updated while counting

   reg  [`TDAC_SEC_W-1:0] sec_alm_q;
   reg  [`TDAC_MIN_W-1:0] min_alm_q;
   reg  [`TDAC_HR_W-1:0]  hr_alm_q;
   reg  [`TDAC_DAY_W-1:0] day_alm_q;

   wire [`TDAC_SEC_W-1:0] sec_cnt;
   wire [`TDAC_SEC_W-1:0] sec_lat;
   wire [`TDAC_MIN_W-1:0] min_cnt;
   wire [`TDAC_MIN_W-1:0] min_lat;
   wire [`TDAC_HR_W-1:0]  hr_cnt;
   wire [`TDAC_HR_W-1:0]  hr_lat;
   wire [`TDAC_DAY_W-1:0] day_cnt;
   wire [`TDAC_DAY_W-1:0] day_lat;
   wire                   sec_carry;
   wire                   min_carry;
   wire                   hr_carry;

   wire                   cnt_en;
   wire                   req;
   wire                   in_block;
   wire [29:0]            word_off;       // word offset from the block base
   wire [3:0]             idx;
   wire                   wr_now;
   wire [15:0]            wmask;
   wire                   latch_en;
   wire                   alarm_hit;
   wire                   ld_sec;
   wire                   ld_min;
   wire                   ld_hr;
   wire                   ld_day;
   reg  [15:0]            rd_val;
   reg  [15:0]            ctrl_d;

   ////////////////////////////////////////////////////////////////////////////////
   // reset release and time-base input synchronisers

   tdac_sync2 #(.RST_VAL(1'b0)) u_rst_sync (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (I_RST_N),
      .i_d     (1'b1),
      .o_q     (rst_n)
   );

   tdac_sync2 #(.RST_VAL(1'b0)) u_tod_sync (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (rst_n),
      .i_d     (I_TOD_CLK),
      .o_q     (tod_clk_s)
   );

   // rising edge of the slow input clock, seen on the bus clock
   always @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         tod_clk_q <= 1'b0;
      end else begin
         tod_clk_q <= tod_clk_s;
      end
   end

   assign tod_rise = tod_clk_s & ~tod_clk_q;
   assign cnt_en   = ctrl_q[`TDAC_CS_CNT_EN];

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode: classic wishbone, one wait state, writes land with ack

   assign req      = I_WB_CYC & I_WB_STB;
   assign in_block = (I_WB_ADR[31:2] >= `TDAC_BASE_WORD) &&
                     (I_WB_ADR[31:2] <= `TDAC_BASE_WORD + {26'h0, `TDAC_IDX_LAST});
   assign word_off = I_WB_ADR[31:2] - `TDAC_BASE_WORD;
   assign idx      = word_off[3:0];
   assign wr_now   = req & I_WB_WE & O_WB_ACK & in_block;
   assign wmask    = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

   // time counters take software writes only while stopped
   assign ld_sec = wr_now & ~cnt_en & (idx == `TDAC_IDX_SEC);
   assign ld_min = wr_now & ~cnt_en & (idx == `TDAC_IDX_MIN);
   assign ld_hr  = wr_now & ~cnt_en & (idx == `TDAC_IDX_HR);
   assign ld_day = wr_now & ~cnt_en & (idx == `TDAC_IDX_DAY);

   // ack rises one cycle after the request and drops the cycle after
   always @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_WB_ACK <= 1'b0;
      end else begin
         O_WB_ACK <= req & ~O_WB_ACK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // prescaler: counts input edges 0..load, then emits the tick

   always @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_q <= {PRE_W{1'b0}};
         tick_q    <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (cnt_en && tod_rise) begin
            if (pre_cnt_q >= pre_load_q) begin
               pre_cnt_q <= {PRE_W{1'b0}};
               tick_q    <= 1'b1;
            end else begin
               pre_cnt_q <= pre_cnt_q + {{(PRE_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // prescale load is written only while stopped
   always @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pre_load_q <= `TDAC_RST_16;
      end else if (wr_now && !cnt_en && idx == `TDAC_IDX_PRESCALE) begin
         pre_load_q <= (pre_load_q & ~wmask) | (I_WB_DAT[15:0] & wmask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // cascaded time fields

   tdac_time_field #(.W(`TDAC_SEC_W), .MAX(`TDAC_SEC_MAX)) u_sec (
      .i_clk      (I_SYS_CLK),
      .i_rst_n    (rst_n),
      .i_inc      (tick_q),
      .i_load     (ld_sec),
      .i_load_val (I_WB_DAT[`TDAC_SEC_W-1:0]),
      .i_latch    (latch_en),
      .o_cnt_q    (sec_cnt),
      .o_lat_q    (sec_lat),
      .o_carry    (sec_carry)
   );

   tdac_time_field #(.W(`TDAC_MIN_W), .MAX(`TDAC_MIN_MAX)) u_min (
      .i_clk      (I_SYS_CLK),
      .i_rst_n    (rst_n),
      .i_inc      (sec_carry),
      .i_load     (ld_min),
      .i_load_val (I_WB_DAT[`TDAC_MIN_W-1:0]),
      .i_latch    (latch_en),
      .o_cnt_q    (min_cnt),
      .o_lat_q    (min_lat),
      .o_carry    (min_carry)
   );

   tdac_time_field #(.W(`TDAC_HR_W), .MAX(`TDAC_HR_MAX)) u_hr (
      .i_clk      (I_SYS_CLK),
      .i_rst_n    (rst_n),
      .i_inc      (min_carry),
      .i_load     (ld_hr),
      .i_load_val (I_WB_DAT[`TDAC_HR_W-1:0]),
      .i_latch    (latch_en),
      .o_cnt_q    (hr_cnt),
      .o_lat_q    (hr_lat),
      .o_carry    (hr_carry)
   );

   tdac_time_field #(.W(`TDAC_DAY_W), .MAX(`TDAC_DAY_MAX)) u_day (
      .i_clk      (I_SYS_CLK),
      .i_rst_n    (rst_n),
      .i_inc      (hr_carry),
      .i_load     (ld_day),
      .i_load_val (I_WB_DAT[`TDAC_DAY_W-1:0]),
      .i_latch    (latch_en),
      .o_cnt_q    (day_cnt),
      .o_lat_q    (day_lat),
      .o_carry    ()
   );

   ////////////////////////////////////////////////////////////////////////////////
   // latch timing: two bus clocks after the tick, or track while stopped

   always @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         tick_dly_q  <= {`TDAC_LATCH_DELAY{1'b0}};
         alarm_chk_q <= 1'b0;
      end else begin
         tick_dly_q  <= {tick_dly_q[`TDAC_LATCH_DELAY-2:0], tick_q};
         alarm_chk_q <= tick_dly_q[`TDAC_LATCH_DELAY-1] & cnt_en;
      end
   end

   assign latch_en = tick_dly_q[`TDAC_LATCH_DELAY-1] | ~cnt_en;

   ////////////////////////////////////////////////////////////////////////////////
   // alarm compare against the freshly latched time

   assign alarm_hit = alarm_chk_q & ctrl_q[`TDAC_CS_ALM_IRQ_EN] &
                      (|ctrl_q[`TDAC_CS_DAY_EN:`TDAC_CS_SEC_EN]) &
                      (~ctrl_q[`TDAC_CS_DAY_EN] | (day_lat == day_alm_q)) &
                      (~ctrl_q[`TDAC_CS_HR_EN]  | (hr_lat  == hr_alm_q))  &
                      (~ctrl_q[`TDAC_CS_MIN_EN] | (min_lat == min_alm_q)) &
                      (~ctrl_q[`TDAC_CS_SEC_EN] | (sec_lat == sec_alm_q));

   // alarm value registers, writable at any time
   always @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sec_alm_q <= {`TDAC_SEC_W{1'b0}};
         min_alm_q <= {`TDAC_MIN_W{1'b0}};
         hr_alm_q  <= {`TDAC_HR_W{1'b0}};
         day_alm_q <= `TDAC_RST_16;
      end else if (wr_now) begin
         case (idx)
            `TDAC_IDX_SEC_ALM: begin
               sec_alm_q <= I_WB_DAT[`TDAC_SEC_W-1:0];
            end
            `TDAC_IDX_MIN_ALM: begin
               min_alm_q <= I_WB_DAT[`TDAC_MIN_W-1:0];
            end
            `TDAC_IDX_HR_ALM: begin
               hr_alm_q <= I_WB_DAT[`TDAC_HR_W-1:0];
            end
            `TDAC_IDX_DAY_ALM: begin
               day_alm_q <= (day_alm_q & ~wmask) | (I_WB_DAT[15:0] & wmask);
            end
            default: begin
               day_alm_q <= day_alm_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control_status next value: writable fields, flags cleared by zero, set wins

   always @* begin
      ctrl_d = ctrl_q;
      if (wr_now && idx == `TDAC_IDX_CTRL) begin
         if (I_WB_SEL[0]) begin
            ctrl_d[7:0] = I_WB_DAT[7:0];
         end
         if (I_WB_SEL[1]) begin
            ctrl_d[`TDAC_CS_TEST_HI:`TDAC_CS_TEST_LO] =
               I_WB_DAT[`TDAC_CS_TEST_HI:`TDAC_CS_TEST_LO];
            if (!I_WB_DAT[`TDAC_CS_SEC_FLAG]) begin
               ctrl_d[`TDAC_CS_SEC_FLAG] = 1'b0;
            end
            if (!I_WB_DAT[`TDAC_CS_ALM_FLAG]) begin
               ctrl_d[`TDAC_CS_ALM_FLAG] = 1'b0;
            end
         end
      end
      if (tick_q) begin
         ctrl_d[`TDAC_CS_SEC_FLAG] = 1'b1;
      end
      if (alarm_hit) begin
         ctrl_d[`TDAC_CS_ALM_FLAG] = 1'b1;
      end
      ctrl_d[13:10] = 4'h0;
      ctrl_d[1]     = 1'b0;
   end

   always @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `TDAC_RST_16;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux: time registers always come from the latches

   always @* begin
      case (idx)
         `TDAC_IDX_CTRL:     rd_val = ctrl_q;
         `TDAC_IDX_PRESCALE: rd_val = pre_load_q;
         `TDAC_IDX_SEC:      rd_val = {10'h000, sec_lat};
         `TDAC_IDX_SEC_ALM:  rd_val = {10'h000, sec_alm_q};
         `TDAC_IDX_MIN:      rd_val = {10'h000, min_lat};
         `TDAC_IDX_MIN_ALM:  rd_val = {10'h000, min_alm_q};
         `TDAC_IDX_HR:       rd_val = {11'h000, hr_lat};
         `TDAC_IDX_HR_ALM:   rd_val = {11'h000, hr_alm_q};
         `TDAC_IDX_DAY:      rd_val = day_lat;
         `TDAC_IDX_DAY_ALM:  rd_val = day_alm_q;
         default:            rd_val = 16'h0000;
      endcase
   end

   // read data registered with the ack; unmapped words read zero
   always @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_WB_DAT <= 32'h0000_0000;
      end else if (req && !O_WB_ACK) begin
         O_WB_DAT <= in_block ? {16'h0000, rd_val} : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt request levels to the interrupt controller

   always @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_SEC_IRQ   <= 1'b0;
         O_ALARM_IRQ <= 1'b0;
      end else begin
         O_SEC_IRQ   <= ctrl_q[`TDAC_CS_SEC_FLAG] & ctrl_q[`TDAC_CS_SEC_IRQ_EN];
         O_ALARM_IRQ <= ctrl_q[`TDAC_CS_ALM_FLAG] & ctrl_q[`TDAC_CS_ALM_IRQ_EN];
      end
   end

endmodule // tdac_top

// ### tb/tdac_top_properties.sv
// concurrent checks on the ports of the time-of-day alarm counter
`timescale 1ns/100ps
`include "tdac_defines.vh"
module tdac_top_properties #(
   parameter PRE_W = 16
) (
   input wire        I_SYS_CLK,
   input wire        I_RST_N,
   input wire        I_TOD_CLK,
   input wire        I_WB_CYC,
   input wire        I_WB_STB,
   input wire        I_WB_WE,
   input wire [31:0] I_WB_ADR,
   input wire [3:0]  I_WB_SEL,
   input wire [31:0] I_WB_DAT,
   input wire        O_WB_ACK,
   input wire [31:0] O_WB_DAT,
   input wire        O_SEC_IRQ,
   input wire        O_ALARM_IRQ
);
   //////////////////////////////////////////
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_N);
   // address decode seen from the bus side
   wire ctrl_hit = (I_WB_ADR[31:2] == `TDAC_BASE_WORD);
   wire map_hit  = (I_WB_ADR[31:2] >= `TDAC_BASE_WORD) &&
                   (I_WB_ADR[31:2] <= `TDAC_BASE_WORD + 30'h9);
   wire ctrl_wr  = O_WB_ACK && I_WB_WE && ctrl_hit;
   //////////////////////////////////////////
   a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack held longer than one cycle");
   a_ack_follows: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
      else $error("request not answered next cycle");
   a_ack_cause: assert property ($rose(O_WB_ACK) |-> $past(I_WB_CYC && I_WB_STB))
      else $error("ack without request");
   a_dat_upper: assert property (O_WB_ACK |-> O_WB_DAT[31:16] == 16'h0)
      else $error("upper read data not zero");
   a_ctrl_unimpl: assert property (O_WB_ACK && !I_WB_WE && ctrl_hit |->
      O_WB_DAT[13:10] == 4'h0 && !O_WB_DAT[1])
      else $error("unimplemented control bits read nonzero");
   a_unmapped_zero: assert property (O_WB_ACK && !I_WB_WE && !map_hit |-> O_WB_DAT == 32'h0)
      else $error("unmapped read not zero");
   a_dat_holds: assert property (!$past(I_WB_CYC && I_WB_STB) |-> $stable(O_WB_DAT))
      else $error("read data changed without request");
   a_sec_irq_clear: assert property ($fell(O_SEC_IRQ) |-> $past(ctrl_wr, 2))
      else $error("second request dropped without control write");
   a_alarm_irq_clear: assert property ($fell(O_ALARM_IRQ) |-> $past(ctrl_wr, 2))
      else $error("alarm request dropped without control write");
endmodule // tdac_top_properties

bind tdac_top tdac_top_properties #(.PRE_W(PRE_W)) tdac_top_properties_inst (
   .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_TOD_CLK(I_TOD_CLK),
   .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
   .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_WB_DAT(O_WB_DAT),
   .O_SEC_IRQ(O_SEC_IRQ), .O_ALARM_IRQ(O_ALARM_IRQ));

// ### tb/tdac_top_test.sv
// self-checking bench for the time-of-day alarm counter
`timescale 1ns/100ps
`include "tdac_defines.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tdac_top_test;
   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   logic        tod   = 1'b0;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [31:0] adr   = 32'h0;
   logic [31:0] wdat  = 32'h0;
   wire         ack;
   wire  [31:0] rdat;
   wire         irq_s;
   wire         irq_a;
   integer      n_fail  = 0;
   integer      checked = 0;
   //////////////////////////////////////////
   tdac_top tdac_top_inst (
      .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_TOD_CLK(tod), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h3), .I_WB_DAT(wdat), .O_WB_ACK(ack),
      .O_WB_DAT(rdat), .O_SEC_IRQ(irq_s), .O_ALARM_IRQ(irq_a));
   // bus clock, 8 ns period
   always #4 clk = ~clk;
   //////////////////////////////////////////
   // one classic cycle, held until ack is sampled high
   task wb(input logic w, input logic [3:0] idx, input logic [15:0] d, output logic [15:0] q);
      integer k;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {`TDAC_BASE_WORD + {26'h0, idx}, 2'b00};
      wdat <= {16'h0, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = rdat[15:0];
      if (k >= 20) n_fail++; // a missing ack counts as a mismatch
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask
   task wr(input logic [3:0] idx, input logic [15:0] d);
      logic [15:0] q;
      wb(1'b1, idx, d, q);
   endtask
   task rd(input logic [3:0] idx, input logic [15:0] e, input string nm);
      logic [15:0] q;
      wb(1'b0, idx, 16'h0, q);
      `CHK(nm, e, q)
   endtask
   // input clock edges, high held four bus clocks, low five between pulses, then settle
   task tod_pulse(input integer n);
      repeat (n) begin
         @(posedge clk) tod <= 1'b1;
         repeat (4) @(posedge clk);
         tod <= 1'b0;
         repeat (4) @(posedge clk);
      end
      repeat (12) @(posedge clk);
   endtask
   //////////////////////////////////////////
   task t_reset;
      for (int i = 0; i < 10; i++) rd(i[3:0], 16'h0, "reset value");
      $display("test reset done");
   endtask
   task t_ctrl;
      wr(`TDAC_IDX_CTRL, 16'hfffe);
      rd(`TDAC_IDX_CTRL, 16'h03fc, "control bits");
      wr(`TDAC_IDX_CTRL, 16'h0);
      wr(4'ha, 16'h1234);
      rd(4'ha, 16'h0, "unmapped");
      wr(`TDAC_IDX_HR_ALM, 16'h0017);
      rd(`TDAC_IDX_HR_ALM, 16'h0017, "alarm value");
      $display("test control done");
   endtask
   task t_count;
      wr(`TDAC_IDX_PRESCALE, 16'h0002);
      wr(`TDAC_IDX_SEC, 16'h003a);
      wr(`TDAC_IDX_MIN, 16'h003b);
      wr(`TDAC_IDX_HR, 16'h0017);
      wr(`TDAC_IDX_DAY, 16'hffff);
      rd(`TDAC_IDX_SEC, 16'h003a, "seconds loaded");
      wr(`TDAC_IDX_CTRL, 16'h0009);
      tod_pulse(2);
      rd(`TDAC_IDX_SEC, 16'h003a, "before tick");
      tod_pulse(1);
      rd(`TDAC_IDX_SEC, 16'h003b, "after tick");
      `CHK("second request", 1'b1, irq_s)
      rd(`TDAC_IDX_CTRL, 16'h8009, "second flag");
      wr(`TDAC_IDX_CTRL, 16'h0009);
      rd(`TDAC_IDX_CTRL, 16'h0009, "flag cleared");
      `CHK("second request off", 1'b0, irq_s)
      tod_pulse(3);
      rd(`TDAC_IDX_SEC, 16'h0, "seconds wrap");
      rd(`TDAC_IDX_MIN, 16'h0, "minutes wrap");
      rd(`TDAC_IDX_HR, 16'h0, "hours wrap");
      rd(`TDAC_IDX_DAY, 16'h0, "days wrap");
      wr(`TDAC_IDX_SEC, 16'h0005);
      rd(`TDAC_IDX_SEC, 16'h0, "write while counting");
      wr(`TDAC_IDX_CTRL, 16'h0);
      tod_pulse(3);
      rd(`TDAC_IDX_SEC, 16'h0, "frozen");
      $display("test counting done");
   endtask
   task t_alarm(input logic [15:0] c, input logic [15:0] sa, input logic e, input string nm);
      logic [15:0] q;
      wr(`TDAC_IDX_CTRL, 16'h0);
      wr(`TDAC_IDX_PRESCALE, 16'h0);
      wr(`TDAC_IDX_SEC, 16'h000a);
      wr(`TDAC_IDX_SEC_ALM, sa);
      wr(`TDAC_IDX_HR_ALM, 16'h0005);
      wr(`TDAC_IDX_CTRL, c);
      tod_pulse(1);
      `CHK(nm, e, irq_a)
      wb(1'b0, `TDAC_IDX_CTRL, 16'h0, q);
      `CHK(nm, e, q[14])
      wr(`TDAC_IDX_CTRL, c);
      rd(`TDAC_IDX_SEC, 16'h000b, nm);
      `CHK(nm, 1'b0, irq_a)
      $display("test alarm %s done", nm);
   endtask
   //////////////////////////////////////////
   // verdict and end of run
   task stop_test;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset;
      t_ctrl;
      t_count;
      t_alarm(16'h0015, 16'h000b, 1'b1, "seconds match");
      t_alarm(16'h00b5, 16'h000b, 1'b1, "all but hours");
      t_alarm(16'h0011, 16'h000b, 1'b0, "master off");
      t_alarm(16'h0055, 16'h000b, 1'b0, "hours differ");
      t_alarm(16'h0005, 16'h000b, 1'b0, "no field");
      t_alarm(16'h0015, 16'h000c, 1'b0, "seconds differ");
      stop_test;
   end
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test;
   end
endmodule // tdac_top_test
